/* verilog/tdes_defines.svh */
// Named constants for the tape drive status report block
`ifndef TDES_DEFINES_SVH
`define TDES_DEFINES_SVH
`define TDES_BIT_CTL 7
`define TDES_BIT_SERVO 6
`define TDES_BIT_FMTR 5
`define TDES_BIT_POS 4
`define TDES_BIT_PAR 3
`define TDES_BIT_PWR 2
`define TDES_BIT_NRZI 1
`define TDES_BIT_PE 0
`define TDES_RETRY_HI 7
`define TDES_RETRY_LO 3
`define TDES_CLASS_HI 2
`define TDES_CLASS_LO 0
`define TDES_CLS_NONE 3'h0
`define TDES_CLS_DEV 3'h2
`define TDES_CLS_PROTO 3'h3
`define TDES_CLS_SELFTEST 3'h7
`define TDES_FLAGS_RST 8'h04
`define TDES_BYTE_RST 8'h00
`define TDES_ONLINE_RST 1'b0
`define TDES_C_WR_PROT 8'h05
`define TDES_C_NO_TAPE 8'h06
`define TDES_C_DENS_NA 8'h07
`define TDES_C_UNID_RD 8'h09
`define TDES_C_UNID_WR 8'h0A
`define TDES_C_OFFLINE 8'h0B
`define TDES_C_NOT_BOT 8'h10
`define TDES_C_AT_BOT 8'h13
`define TDES_C_NOT_SYNC 8'h17
`define TDES_C_UNK_CMD 8'h18
`define TDES_C_REC_LONG 8'h1F
`define TDES_C_PAST_EOT 8'h20
`define TDES_C_SELFTEST 8'h21
`define TDES_C_DOOR_GAP 8'h28
`define TDES_C_DATA_BASE 8'h29
`define TDES_C_SERVO_BASE 8'h51
`define TDES_C_SHUTDOWN 8'h53
`define TDES_C_POS_FAIL 8'h5E
`endif

/* verilog/tdes_pkg.sv */
// Types shared by the tape drive status report modules
package tdes_pkg;
    typedef enum logic [3:0] {
        REJ_WR_PROT, REJ_NO_TAPE, REJ_DENS_NA, REJ_UNID_RD, REJ_UNID_WR,
        REJ_OFFLINE, REJ_NOT_BOT, REJ_AT_BOT, REJ_NOT_SYNC, REJ_UNK_CMD,
        REJ_REC_LONG, REJ_PAST_EOT, REJ_DOOR_GAP
    } tdes_rej_cause_t;
    typedef enum logic [3:0] {
        DAT_VELOCITY, DAT_MULTI_TRK, DAT_VERIFY, DAT_NOISE, DAT_FORMAT,
        DAT_GAP_IN_DATA, DAT_DROPOUT, DAT_REDUNDANCY, DAT_RD_PARITY,
        DAT_DOOR_ABORT, DAT_WR_CORRECTED, DAT_OVERRUN, DAT_BLK_TIMEOUT,
        DAT_TM_DROPOUT, DAT_TM_UNVERIFIED, DAT_TM_TIMEOUT
    } tdes_data_cause_t;
    typedef enum logic [2:0] {
        FMT_NONE, FMT_NRZI, FMT_PE, FMT_GCR, FMT_BLANK, FMT_UNKNOWN
    } tdes_tape_fmt_t;
endpackage : tdes_pkg

/* verilog/tdes_evt_if.sv */
// Fault causes in, chosen detail code out
`timescale 1ns/1ps
interface tdes_evt_if;
    import tdes_pkg::*;
    logic ctl_fault;
    logic [7:0] ctl_code;
    logic servo_fault;
    logic [3:0] servo_idx;
    logic fmt_fault;
    logic [7:0] fmt_code;
    logic tension_lost;
    logic pos_fail;
    logic data_err;
    tdes_data_cause_t data_cause;
    logic rej_valid;
    logic [7:0] rej_code;
    logic sel_valid;
    logic [7:0] sel_code;
    modport src (output ctl_fault, ctl_code, servo_fault, servo_idx, fmt_fault, fmt_code,
        tension_lost, pos_fail, data_err, data_cause, rej_valid, rej_code,
        input sel_valid, sel_code);
    modport sel (input ctl_fault, ctl_code, servo_fault, servo_idx, fmt_fault, fmt_code,
        tension_lost, pos_fail, data_err, data_cause, rej_valid, rej_code,
        output sel_valid, sel_code);
endinterface : tdes_evt_if

/* verilog/tdes_cmd_parity.sv */
// Synchronised odd parity check on bus command bytes
`timescale 1ns/1ps
`include "tdes_defines.svh"
module tdes_cmd_parity (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] bus_data_lines,
    input wire logic bus_cmd_strobe,
    output logic parity_err_r
);
    logic [7:0] d_s1_r, d_s2_r;
    logic st_s1_r, st_s2_r, st_s3_r;
    logic parity_err_nxt;

    always_comb begin
        // Odd count of ones is correct
        parity_err_nxt = st_s2_r && !st_s3_r && !(^d_s2_r);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            d_s1_r <= `TDES_BYTE_RST;
            d_s2_r <= `TDES_BYTE_RST;
            st_s1_r <= 1'b0;
            st_s2_r <= 1'b0;
            st_s3_r <= 1'b0;
            parity_err_r <= 1'b0;
        end else begin
            d_s1_r <= bus_data_lines;
            d_s2_r <= d_s1_r;
            st_s1_r <= bus_cmd_strobe;
            st_s2_r <= st_s1_r;
            st_s3_r <= st_s2_r;
            parity_err_r <= parity_err_nxt;
        end
    end

    even_byte_a: assert property (@(posedge clk) disable iff (rst)
        (st_s2_r && !st_s3_r && !(^d_s2_r)) |=> parity_err_r)
        else $error("even parity byte not flagged");
    odd_byte_a: assert property (@(posedge clk) disable iff (rst)
        (st_s2_r && !st_s3_r && (^d_s2_r)) |=> !parity_err_r)
        else $error("odd parity byte flagged");
endmodule : tdes_cmd_parity

/* verilog/tdes_detail_sel.sv */
// Picks the detail code of the highest priority cause
`timescale 1ns/1ps
`include "tdes_defines.svh"
module tdes_detail_sel
    import tdes_pkg::*;
(
    tdes_evt_if.sel ev
);
    function automatic logic [7:0] data_code(input tdes_data_cause_t c);
        unique case (c)
            DAT_VELOCITY: data_code = `TDES_C_DATA_BASE;
            DAT_MULTI_TRK: data_code = `TDES_C_DATA_BASE + 8'h04;
            DAT_VERIFY: data_code = `TDES_C_DATA_BASE + 8'h06;
            DAT_NOISE: data_code = `TDES_C_DATA_BASE + 8'h07;
            DAT_FORMAT: data_code = `TDES_C_DATA_BASE + 8'h08;
            DAT_GAP_IN_DATA: data_code = `TDES_C_DATA_BASE + 8'h0A;
            DAT_DROPOUT: data_code = `TDES_C_DATA_BASE + 8'h0B;
            DAT_REDUNDANCY: data_code = `TDES_C_DATA_BASE + 8'h0C;
            DAT_RD_PARITY: data_code = `TDES_C_DATA_BASE + 8'h0D;
            DAT_DOOR_ABORT: data_code = `TDES_C_DATA_BASE + 8'h0E;
            DAT_WR_CORRECTED: data_code = `TDES_C_DATA_BASE + 8'h12;
            DAT_OVERRUN: data_code = `TDES_C_DATA_BASE + 8'h13;
            DAT_BLK_TIMEOUT: data_code = `TDES_C_DATA_BASE + 8'h14;
            DAT_TM_DROPOUT: data_code = `TDES_C_DATA_BASE + 8'h15;
            DAT_TM_UNVERIFIED: data_code = `TDES_C_DATA_BASE + 8'h16;
            DAT_TM_TIMEOUT: data_code = `TDES_C_DATA_BASE + 8'h17;
        endcase
    endfunction : data_code

    // Controller, servo, formatter, position, data, reject
    always_comb begin
        ev.sel_valid = 1'b1;
        if (ev.ctl_fault) begin
            ev.sel_code = ev.ctl_code;
        end else if (ev.servo_fault) begin
            ev.sel_code = `TDES_C_SERVO_BASE + {4'h0, ev.servo_idx};
        end else if (ev.fmt_fault) begin
            ev.sel_code = ev.fmt_code;
        end else if (ev.tension_lost) begin
            ev.sel_code = `TDES_C_SHUTDOWN;
        end else if (ev.pos_fail) begin
            ev.sel_code = `TDES_C_POS_FAIL;
        end else if (ev.data_err) begin
            ev.sel_code = data_code(ev.data_cause);
        end else if (ev.rej_valid) begin
            ev.sel_code = ev.rej_code;
        end else begin
            ev.sel_valid = 1'b0;
            ev.sel_code = `TDES_BYTE_RST;
        end
    end
endmodule : tdes_detail_sel

/* verilog/tdes_status.sv */
// Error flag, retry and detail code status bytes of the tape drive
// Behaviour
// - Controller fault sets flag bit 7, detail
// - Servo fault sets flag bit 6, detail
// - Formatter fault sets flag bit 5, detail
// - Lost position/tension sets bit 4; tension offline
// - Even parity command byte sets bit 3
// - Power-up, recovery, device clear set bit 2
// - Bit 1 marks NRZI tape
// - Bit 0 marks PE tape
// - Five-bit retry count in upper field
// - Reject class: 0, 2, 3 or 7
// - Asserted flag chooses detail code set
// - Device reject codes 5, 6, 7, 11
// - Unidentified tape codes 9 and 10
// - Codes 16 off BOT, 19 at BOT
// - Codes 23, 24, 31 for command faults
// - Codes 32, 33, 40; 40 never retried
// - Data error codes 41 to 49
// - Data error codes 51 to 54
// - Data error codes 55 to 64
// - Servo codes 81 to 92, positioning 94
// - Highest priority cause wins the detail byte
// - Any reject sets command-rejected flag
`timescale 1ns/1ps
`include "tdes_defines.svh"
module tdes_status
    import tdes_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] bus_data_lines,
    input wire logic bus_cmd_strobe,
    input wire logic ctl_fault,
    input wire logic [7:0] ctl_code,
    input wire logic servo_fault,
    input wire logic [3:0] servo_idx,
    input wire logic fmt_fault,
    input wire logic [7:0] fmt_code,
    input wire logic pos_lost,
    input wire logic pos_fail,
    input wire logic tension_lost,
    input wire logic go_online,
    input wire logic data_err,
    input wire tdes_data_cause_t data_cause,
    input wire logic dev_reject,
    input wire tdes_rej_cause_t rej_cause,
    input wire logic proto_reject,
    input wire logic [7:0] proto_code,
    input wire logic selftest_fail,
    input wire logic power_recovered,
    input wire logic device_clear,
    input wire logic fmt_update,
    input wire tdes_tape_fmt_t fmt_seen,
    input wire logic tape_unload,
    input wire logic op_done,
    input wire logic [4:0] retry_count,
    input wire logic status_read,
    output logic [7:0] err_flags_r,
    output logic [7:0] retry_class_r,
    output logic [7:0] detail_code_r,
    output logic cmd_rejected_r,
    output logic drive_online_r
);
    logic parity_err;
    logic [7:0] err_flags_nxt;
    logic [7:0] retry_class_nxt;
    logic [7:0] detail_code_nxt;
    logic cmd_rejected_nxt;
    logic drive_online_nxt;
    logic any_reject;
    logic [7:0] rej_code;
    logic [7:0] ev_set;

    tdes_evt_if ev ();

    tdes_cmd_parity u_parity (
        .clk(clk),
        .rst(rst),
        .bus_data_lines(bus_data_lines),
        .bus_cmd_strobe(bus_cmd_strobe),
        .parity_err_r(parity_err)
    );

    tdes_detail_sel u_sel (
        .ev(ev.sel)
    );

    function automatic logic [7:0] dev_code(input tdes_rej_cause_t c);
        unique case (c)
            REJ_WR_PROT: dev_code = `TDES_C_WR_PROT;
            REJ_NO_TAPE: dev_code = `TDES_C_NO_TAPE;
            REJ_DENS_NA: dev_code = `TDES_C_DENS_NA;
            REJ_UNID_RD: dev_code = `TDES_C_UNID_RD;
            REJ_UNID_WR: dev_code = `TDES_C_UNID_WR;
            REJ_OFFLINE: dev_code = `TDES_C_OFFLINE;
            REJ_NOT_BOT: dev_code = `TDES_C_NOT_BOT;
            REJ_AT_BOT: dev_code = `TDES_C_AT_BOT;
            REJ_NOT_SYNC: dev_code = `TDES_C_NOT_SYNC;
            REJ_UNK_CMD: dev_code = `TDES_C_UNK_CMD;
            REJ_REC_LONG: dev_code = `TDES_C_REC_LONG;
            REJ_PAST_EOT: dev_code = `TDES_C_PAST_EOT;
            REJ_DOOR_GAP: dev_code = `TDES_C_DOOR_GAP;
            default: dev_code = `TDES_BYTE_RST;
        endcase
    endfunction : dev_code

    // Reject cause ranking: selftest, device, protocol
    always_comb begin
        any_reject = selftest_fail || dev_reject || proto_reject;
        if (selftest_fail) begin
            rej_code = `TDES_C_SELFTEST;
        end else if (dev_reject) begin
            rej_code = dev_code(rej_cause);
        end else begin
            rej_code = proto_code;
        end
    end

    always_comb begin
        ev.ctl_fault = ctl_fault;
        ev.ctl_code = ctl_code;
        ev.servo_fault = servo_fault;
        ev.servo_idx = servo_idx;
        ev.fmt_fault = fmt_fault;
        ev.fmt_code = fmt_code;
        ev.tension_lost = tension_lost;
        ev.pos_fail = pos_fail;
        ev.data_err = data_err;
        ev.data_cause = data_cause;
        ev.rej_valid = any_reject;
        ev.rej_code = rej_code;
    end

    // Error flags: sticky, set beats report clear
    always_comb begin
        ev_set = 8'h00;
        ev_set[`TDES_BIT_CTL] = ctl_fault;
        ev_set[`TDES_BIT_SERVO] = servo_fault;
        ev_set[`TDES_BIT_FMTR] = fmt_fault;
        ev_set[`TDES_BIT_POS] = pos_lost || pos_fail || tension_lost;
        ev_set[`TDES_BIT_PAR] = parity_err;
        ev_set[`TDES_BIT_PWR] = power_recovered || device_clear;
        err_flags_nxt = err_flags_r;
        if (status_read) begin
            err_flags_nxt[`TDES_BIT_CTL:`TDES_BIT_PWR] = 6'h00;
        end
        err_flags_nxt = err_flags_nxt | ev_set;
        if (tape_unload) begin
            err_flags_nxt[`TDES_BIT_NRZI] = 1'b0;
            err_flags_nxt[`TDES_BIT_PE] = 1'b0;
        end else if (fmt_update) begin
            err_flags_nxt[`TDES_BIT_NRZI] = (fmt_seen == FMT_NRZI);
            err_flags_nxt[`TDES_BIT_PE] = (fmt_seen == FMT_PE);
        end
    end

    // Retry count and reject class
    always_comb begin
        retry_class_nxt = retry_class_r;
        if (status_read) begin
            retry_class_nxt[`TDES_CLASS_HI:`TDES_CLASS_LO] = `TDES_CLS_NONE;
        end
        if (op_done) begin
            retry_class_nxt[`TDES_RETRY_HI:`TDES_RETRY_LO] = retry_count;
        end
        if (selftest_fail) begin
            retry_class_nxt[`TDES_CLASS_HI:`TDES_CLASS_LO] = `TDES_CLS_SELFTEST;
        end else if (dev_reject) begin
            retry_class_nxt[`TDES_CLASS_HI:`TDES_CLASS_LO] = `TDES_CLS_DEV;
            if (rej_cause == REJ_DOOR_GAP) begin
                retry_class_nxt[`TDES_RETRY_HI:`TDES_RETRY_LO] = 5'h00;
            end
        end else if (proto_reject) begin
            retry_class_nxt[`TDES_CLASS_HI:`TDES_CLASS_LO] = `TDES_CLS_PROTO;
        end
    end

    // Detail byte, command reject flag, online state
    always_comb begin
        detail_code_nxt = detail_code_r;
        if (ev.sel_valid) begin
            detail_code_nxt = ev.sel_code;
        end
        cmd_rejected_nxt = cmd_rejected_r;
        if (status_read) begin
            cmd_rejected_nxt = 1'b0;
        end
        if (any_reject) begin
            cmd_rejected_nxt = 1'b1;
        end
        drive_online_nxt = drive_online_r;
        if (go_online) begin
            drive_online_nxt = 1'b1;
        end
        if (tension_lost) begin
            drive_online_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_flags_r <= `TDES_FLAGS_RST;
            retry_class_r <= `TDES_BYTE_RST;
            detail_code_r <= `TDES_BYTE_RST;
            cmd_rejected_r <= 1'b0;
            drive_online_r <= `TDES_ONLINE_RST;
        end else begin
            err_flags_r <= err_flags_nxt;
            retry_class_r <= retry_class_nxt;
            detail_code_r <= detail_code_nxt;
            cmd_rejected_r <= cmd_rejected_nxt;
            drive_online_r <= drive_online_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ctl_first_a: assert property (
        ctl_fault |-> ev.sel_valid && ev.sel_code == ctl_code)
        else $error("controller cause lost priority");
    ctl_flag_set_a: assert property (
        ctl_fault |=> err_flags_r[`TDES_BIT_CTL] && detail_code_r == $past(ctl_code))
        else $error("controller fault not reported");
    servo_flag_set_a: assert property (
        servo_fault && !ctl_fault |=> err_flags_r[`TDES_BIT_SERVO]
            && detail_code_r == `TDES_C_SERVO_BASE + {4'h0, $past(servo_idx)})
        else $error("servo fault not reported");
    fmtr_flag_set_a: assert property (
        fmt_fault |=> err_flags_r[`TDES_BIT_FMTR])
        else $error("formatter fault flag missing");
    tension_offline_a: assert property (
        tension_lost |=> !drive_online_r && err_flags_r[`TDES_BIT_POS])
        else $error("tension loss left drive online");
    parity_flag_a: assert property (
        parity_err |=> err_flags_r[`TDES_BIT_PAR])
        else $error("parity error flag missing");
    power_flag_a: assert property (
        device_clear || power_recovered |=> err_flags_r[`TDES_BIT_PWR])
        else $error("power restored flag missing");
    nrzi_bits_a: assert property (
        fmt_update && !tape_unload && fmt_seen == FMT_NRZI |=> err_flags_r[1:0] == 2'h2)
        else $error("NRZI format bits wrong");
    pe_bits_a: assert property (
        fmt_update && !tape_unload && fmt_seen != FMT_PE |=> !err_flags_r[`TDES_BIT_PE])
        else $error("PE bit set for other format");
    retry_latch_a: assert property (
        op_done && !dev_reject && !selftest_fail |=> retry_class_r[7:3] == $past(retry_count))
        else $error("retry count not latched");
    dev_class_a: assert property (
        dev_reject && !selftest_fail |=> retry_class_r[2:0] == `TDES_CLS_DEV)
        else $error("device reject class wrong");
    wr_prot_code_a: assert property (
        dev_reject && rej_cause == REJ_WR_PROT && !ctl_fault && !servo_fault && !fmt_fault
            && !tension_lost && !pos_fail && !data_err && !selftest_fail
            |=> detail_code_r == `TDES_C_WR_PROT)
        else $error("write protect code wrong");
    cmd_rej_flag_a: assert property (
        any_reject |=> cmd_rejected_r [*1] ##0 retry_class_r[2:0] != `TDES_CLS_NONE)
        else $error("reject not flagged");
    detail_hold_a: assert property (
        !ev.sel_valid |=> $stable(detail_code_r))
        else $error("detail byte changed without event");

    reject_seen_c: cover property (dev_reject ##[1:3] status_read);
    data_err_c: cover property (data_err && dev_reject);
    tension_c: cover property (go_online ##[1:20] tension_lost);
endmodule : tdes_status

/* tb/tdes_host_model.sv */
// Host side model: puts command bytes on the parallel bus lines
`timescale 1ns/1ps
module tdes_host_model (
    input wire logic clk,
    output logic [7:0] bus_data_lines,
    output logic bus_cmd_strobe
);
    initial begin
        bus_data_lines = 8'h00;
        bus_cmd_strobe = 1'b0;
    end

    // Data settles before strobe and outlives it; released lines show the inverse byte
    task automatic send_cmd(input logic [7:0] b);
        @(posedge clk);
        bus_data_lines <= b;
        @(posedge clk);
        bus_cmd_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        bus_cmd_strobe <= 1'b0;
        @(posedge clk);
        bus_data_lines <= ~b;
    endtask : send_cmd
endmodule : tdes_host_model

/* tb/tdes_status_tb.sv */
// Self-checking bench for the tape drive status bytes
`timescale 1ns/1ps
module tdes_status_tb;
    import tdes_pkg::*;
    localparam logic [16:0] CTL = 17'h00001, SRV = 17'h00002, FMT = 17'h00004;
    localparam logic [16:0] PLOST = 17'h00008, PFAIL = 17'h00010, TENS = 17'h00020;
    localparam logic [16:0] ONL = 17'h00040, DAT = 17'h00080, REJ = 17'h00100;
    localparam logic [16:0] PRO = 17'h00200, STF = 17'h00400, PWR = 17'h00800;
    localparam logic [16:0] DCL = 17'h01000, FUP = 17'h02000, UNL = 17'h04000;
    localparam logic [16:0] OPD = 17'h08000, RD = 17'h10000;
    localparam logic [7:0] REJ_EXP [13] = '{8'h05, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0B,
        8'h10, 8'h13, 8'h17, 8'h18, 8'h1F, 8'h20, 8'h28};
    localparam logic [7:0] DAT_EXP [16] = '{8'h29, 8'h2D, 8'h2F, 8'h30, 8'h31, 8'h33,
        8'h34, 8'h35, 8'h36, 8'h37, 8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h40};
    localparam logic [1:0] FMT_EXP [6] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [16:0] ev = 17'h00000;
    logic [7:0] ctl_code = 8'h00;
    logic [7:0] fmt_code = 8'h00;
    logic [7:0] proto_code = 8'h00;
    logic [3:0] servo_idx = 4'h0;
    logic [4:0] retry_count = 5'h00;
    tdes_data_cause_t data_cause = DAT_VELOCITY;
    tdes_rej_cause_t rej_cause = REJ_WR_PROT;
    tdes_tape_fmt_t fmt_seen = FMT_NONE;
    logic [7:0] bus_data_lines;
    logic bus_cmd_strobe;
    logic [7:0] err_flags_r;
    logic [7:0] retry_class_r;
    logic [7:0] detail_code_r;
    logic cmd_rejected_r;
    logic drive_online_r;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;

    always #5 clk = ~clk;

    tdes_host_model u_host (.clk(clk), .bus_data_lines(bus_data_lines),
        .bus_cmd_strobe(bus_cmd_strobe));

    tdes_status u_dut (.clk(clk), .rst(rst), .bus_data_lines(bus_data_lines),
        .bus_cmd_strobe(bus_cmd_strobe), .ctl_fault(ev[0]), .ctl_code(ctl_code),
        .servo_fault(ev[1]), .servo_idx(servo_idx), .fmt_fault(ev[2]), .fmt_code(fmt_code),
        .pos_lost(ev[3]), .pos_fail(ev[4]), .tension_lost(ev[5]), .go_online(ev[6]),
        .data_err(ev[7]), .data_cause(data_cause), .dev_reject(ev[8]), .rej_cause(rej_cause),
        .proto_reject(ev[9]), .proto_code(proto_code), .selftest_fail(ev[10]),
        .power_recovered(ev[11]), .device_clear(ev[12]), .fmt_update(ev[13]),
        .fmt_seen(fmt_seen), .tape_unload(ev[14]), .op_done(ev[15]),
        .retry_count(retry_count), .status_read(ev[16]), .err_flags_r(err_flags_r),
        .retry_class_r(retry_class_r), .detail_code_r(detail_code_r),
        .cmd_rejected_r(cmd_rejected_r), .drive_online_r(drive_online_r));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    // One-cycle event pulse, outputs sampled once the taking edge has settled
    task automatic pulse(input logic [16:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 17'h00000;
        #1;
    endtask : pulse

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk8("flags", 8'h04, err_flags_r);
        chk8("retry_class", 8'h00, retry_class_r);
        chk8("detail", 8'h00, detail_code_r);
        chk1("online", 1'b0, drive_online_r);
        pulse(RD);
        chk8("flags", 8'h00, err_flags_r);
        $display("reset test done");
        for (int i = 0; i < 13; i++) begin
            @(posedge clk) rej_cause <= tdes_rej_cause_t'(i);
            pulse(REJ);
            chk8("detail", REJ_EXP[i], detail_code_r);
            chk8("retry_class", 8'h02, retry_class_r);
            chk1("cmd_rej", 1'b1, cmd_rejected_r);
            pulse(RD);
            chk8("retry_class", 8'h00, retry_class_r);
            chk1("cmd_rej", 1'b0, cmd_rejected_r);
            chk8("detail", REJ_EXP[i], detail_code_r);
        end
        for (int i = 0; i < 16; i++) begin
            @(posedge clk) data_cause <= tdes_data_cause_t'(i);
            pulse(DAT);
            chk8("detail", DAT_EXP[i], detail_code_r);
        end
        for (int i = 0; i < 12; i++) begin
            @(posedge clk) servo_idx <= 4'(i);
            pulse(SRV);
            chk8("detail", 8'h51 + 8'(i), detail_code_r);
            chk8("flags", 8'h40, err_flags_r);
        end
        for (int i = 0; i < 6; i++) begin
            @(posedge clk) fmt_seen <= tdes_tape_fmt_t'(i);
            pulse(FUP);
            chk8("fmt_bits", {6'h00, FMT_EXP[i]}, {6'h00, err_flags_r[1:0]});
        end
        pulse(RD);
        $display("table test done");
        @(posedge clk) fmt_seen <= FMT_PE;
        pulse(FUP | UNL);
        chk8("flags", 8'h00, err_flags_r);
        @(posedge clk) ctl_code <= 8'h79;
        fmt_code <= 8'h66;
        servo_idx <= 4'h3;
        pulse(CTL | SRV | FMT | DAT | REJ);
        chk8("detail", 8'h79, detail_code_r);
        chk8("flags", 8'hE0, err_flags_r);
        pulse(RD);
        pulse(SRV | FMT | TENS | DAT);
        chk8("detail", 8'h54, detail_code_r);
        pulse(FMT | PFAIL | STF);
        chk8("detail", 8'h66, detail_code_r);
        pulse(RD);
        $display("priority test done");
        pulse(ONL);
        chk1("online", 1'b1, drive_online_r);
        pulse(TENS);
        chk8("flags", 8'h10, err_flags_r);
        chk8("detail", 8'h53, detail_code_r);
        chk1("online", 1'b0, drive_online_r);
        pulse(PFAIL);
        chk8("detail", 8'h5E, detail_code_r);
        pulse(RD);
        pulse(PLOST);
        chk8("flags", 8'h10, err_flags_r);
        chk8("detail", 8'h5E, detail_code_r);
        $display("position test done");
        pulse(STF);
        chk8("retry_class", 8'h07, retry_class_r);
        chk8("detail", 8'h21, detail_code_r);
        chk1("cmd_rej", 1'b1, cmd_rejected_r);
        pulse(RD);
        @(posedge clk) proto_code <= 8'hA1;
        pulse(PRO);
        chk8("retry_class", 8'h03, retry_class_r);
        chk8("detail", 8'hA1, detail_code_r);
        chk1("cmd_rej", 1'b1, cmd_rejected_r);
        pulse(RD);
        @(posedge clk) retry_count <= 5'h1F;
        pulse(OPD);
        chk8("retry_class", 8'hF8, retry_class_r);
        @(posedge clk) retry_count <= 5'h01;
        pulse(OPD);
        chk8("retry_class", 8'h08, retry_class_r);
        @(posedge clk) rej_cause <= REJ_DOOR_GAP;
        pulse(REJ);
        chk8("retry_class", 8'h02, retry_class_r);
        pulse(RD);
        $display("class and retry test done");
        pulse(PWR | RD);
        chk8("flags", 8'h04, err_flags_r);
        pulse(RD);
        pulse(DCL);
        chk8("flags", 8'h04, err_flags_r);
        pulse(RD);
        u_host.send_cmd(8'h03);
        repeat (6) @(posedge clk);
        #1;
        chk8("flags", 8'h08, err_flags_r);
        pulse(RD);
        u_host.send_cmd(8'h07);
        repeat (6) @(posedge clk);
        #1;
        chk8("flags", 8'h00, err_flags_r);
        $display("power and parity test done");
        finish_test();
    end
endmodule : tdes_status_tb
